// File: hw/his_pkg.sv
// package for the host interface switch: states, carriers, constants
package his_pkg;

   // interconnect that carries in-band traffic
   typedef enum logic [1:0] {
      HIS_SEL_SMBUS,
      HIS_SEL_PCIE
   } his_sel_t;

   // state of the serial link lanes
   typedef enum logic [1:0] {
      HIS_LANE_ACTIVE,
      HIS_LANE_EIDLE,
      HIS_LANE_OFF
   } his_lane_t;

   // one in-band word toward either interconnect
   typedef struct packed {
      logic       valid;
      logic       last;
      logic [7:0] data;
   } his_beat_t;

   // ethernet link condition as reported by the phy core
   typedef struct packed {
      logic phy_powered_down;
      logic link_idle;
      logic low_power_idle_state;
      logic link_active;
   } his_link_t;

   localparam int          HIS_REF_MHZ      = 25;
   localparam int          HIS_LOGIC_MHZ    = 125;
   localparam int          HIS_PLL_MULT     = HIS_LOGIC_MHZ / HIS_REF_MHZ;
   localparam int          HIS_MSG_DEPTH    = 4;
   localparam logic [1:0]  HIS_SPEED_10M    = 2'h0;
   localparam logic [1:0]  HIS_SPEED_ANY    = 2'h3;
   localparam logic [1:0]  HIS_RST_SYNC_RST = 2'h0;

endpackage

// File: hw/his_switch.sv
// host interface switch: picks the serial link or smbus for in-band traffic
// Contract
// R1: active working state: traffic over serial link
// R2: phy powered down: link electrical idle
// R3: ethernet idle or disconnected: link electrical idle
// R4: low power idle: link electrical idle
// R5: sleep states: link off, all over smbus
// R6: smbus selected after power-on and standby
// R7: reset rising moves traffic to serial link
// R8: reset falling moves traffic to smbus
// R9: drop any packet in flight on switch
// R10: resend unacknowledged smbus messages over link
// R11: resend unacknowledged link messages over smbus
// R12: host engine decides when smbus is used
// R13: clocks derived from one 25 MHz reference; here system and link clocks are plain input ports, nothing is derived
// R14: host raises reset only with power good
// R15: smbus selected limits speed to 10 Mbps
// R16: synchronise reset, switch once per edge
`timescale 1ns/1ps
module his_switch #(
   parameter int MSG_DEPTH = his_pkg::HIS_MSG_DEPTH
) (
   input  wire logic              sys_clk_in,
   input  wire logic              rstn_in,
   input  wire logic              platform_reset_n_in,
   input  wire logic              lnk_clk_in,
   input  wire his_pkg::his_link_t link_state_in,
   input  wire his_pkg::his_beat_t msg_in,
   input  wire logic              msg_ack_in,
   input  wire his_pkg::his_beat_t pkt_in,
   output his_pkg::his_beat_t     pcie_out,
   output his_pkg::his_beat_t     smbus_out,
   output his_pkg::his_sel_t      sel_out,
   output his_pkg::his_lane_t     lane_out,
   output logic [1:0]             speed_cap_out,
   output logic                   pkt_drop_out,
   output logic                   lnk_sel_pcie_out
);

   localparam int PW = $clog2(MSG_DEPTH);

   // whole state of the system-clock side
   typedef struct packed {
      logic [1:0]                   rst_sync;
      logic                         rst_seen;
      his_pkg::his_sel_t            sel;
      his_pkg::his_lane_t           lane;
      logic                         in_pkt;
      logic                         drop;
      logic                         replay;
      logic [PW:0]                  ack_ptr;
      logic [PW:0]                  wr_ptr;
      logic [PW:0]                  rd_ptr;
      logic [MSG_DEPTH-1:0][8:0]    msg_mem;
      his_pkg::his_beat_t           pcie;
      his_pkg::his_beat_t           smbus;
      logic [1:0]                   speed;
   } his_state_t;

   his_state_t st;
   his_state_t next_st;

   // link-clock side: two-stage level crossing of the selection
   typedef struct packed {
      logic [1:0] sel_sync;
      logic       sel_pcie;
   } his_lnk_t;

   his_lnk_t ls;
   his_lnk_t next_ls;

   logic [PW-1:0] rd_idx;
   logic [PW-1:0] wr_idx;
   logic          sw_edge;
   logic          rst_level;

   assign rd_idx    = st.rd_ptr[PW-1:0];
   assign wr_idx    = st.wr_ptr[PW-1:0];
   // only the second sync stage is looked at
   assign rst_level = st.rst_sync[1];
   assign sw_edge   = rst_level != st.rst_seen; // see R16

   always_comb begin
      next_st          = st;
      next_st.rst_sync = {st.rst_sync[0], platform_reset_n_in}; // see R16
      next_st.rst_seen = rst_level;
      next_st.drop     = 1'b0;
      next_st.pcie     = '0;
      next_st.smbus    = '0;

      // R12/R14 are the host's; we only follow the reset level
      if (sw_edge) begin
         next_st.sel    = rst_level ? his_pkg::HIS_SEL_PCIE
                                    : his_pkg::HIS_SEL_SMBUS; // see R7 see R8
         next_st.drop   = st.in_pkt; // see R9
         next_st.in_pkt = 1'b0; // see R9
         // rewind to oldest unacknowledged message
         next_st.rd_ptr = st.ack_ptr; // see R10 see R11
         next_st.replay = st.ack_ptr != st.wr_ptr;
      end

      // lane state from platform and ethernet condition
      if (st.sel == his_pkg::HIS_SEL_SMBUS) begin
         next_st.lane  = his_pkg::HIS_LANE_OFF; // see R5 see R6
         next_st.speed = his_pkg::HIS_SPEED_10M; // see R15
      end else begin
         next_st.speed = his_pkg::HIS_SPEED_ANY;
         if (link_state_in.phy_powered_down) begin
            next_st.lane = his_pkg::HIS_LANE_EIDLE; // see R2
         end else if (link_state_in.low_power_idle_state) begin
            next_st.lane = his_pkg::HIS_LANE_EIDLE; // see R4
         end else if (link_state_in.link_idle || !link_state_in.link_active) begin
            next_st.lane = his_pkg::HIS_LANE_EIDLE; // see R3
         end else begin
            next_st.lane = his_pkg::HIS_LANE_ACTIVE; // see R1
         end
      end

      // packet path: no forwarding on the edge cycle, so nothing half-sent survives
      if (!sw_edge && pkt_in.valid) begin
         next_st.in_pkt = !pkt_in.last;
         if (st.sel == his_pkg::HIS_SEL_PCIE) begin
            next_st.pcie = pkt_in; // see R1
         end else begin
            next_st.smbus = pkt_in; // see R5
         end
      end

      // message store: kept until acknowledged so a switch can resend
      if (msg_ack_in && st.ack_ptr != st.wr_ptr) begin
         next_st.ack_ptr = st.ack_ptr + 1'b1;
      end
      if (msg_in.valid && (st.wr_ptr - st.ack_ptr) != (PW+1)'(MSG_DEPTH)) begin
         next_st.msg_mem[wr_idx] = {msg_in.last, msg_in.data};
         next_st.wr_ptr          = st.wr_ptr + 1'b1;
      end
      // messages share the lane only when no packet beat is out this cycle
      if (!sw_edge && !pkt_in.valid && st.rd_ptr != st.wr_ptr) begin
         next_st.rd_ptr = st.rd_ptr + 1'b1;
         if (st.sel == his_pkg::HIS_SEL_PCIE) begin
            next_st.pcie = {1'b1, st.msg_mem[rd_idx]}; // see R10
         end else begin
            next_st.smbus = {1'b1, st.msg_mem[rd_idx]}; // see R11
         end
         if (next_st.rd_ptr == st.wr_ptr) begin
            next_st.replay = 1'b0;
         end
      end
      // ack may pass a rewound read pointer
      if (!sw_edge && (next_st.rd_ptr - next_st.ack_ptr) > (PW+1)'(MSG_DEPTH)) begin
         next_st.rd_ptr = next_st.ack_ptr;
      end
   end

   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         st          <= '0;
         st.rst_sync <= his_pkg::HIS_RST_SYNC_RST;
         st.sel      <= his_pkg::HIS_SEL_SMBUS; // see R6
         st.lane     <= his_pkg::HIS_LANE_OFF;
         st.speed    <= his_pkg::HIS_SPEED_10M;
      end else begin
         st <= next_st;
      end
   end

   always_comb begin
      next_ls          = ls;
      next_ls.sel_sync = {ls.sel_sync[0], st.sel == his_pkg::HIS_SEL_PCIE};
      next_ls.sel_pcie = ls.sel_sync[1];
   end

   // the link-side selection crossing runs off the pll output (R13); here a plain link clock port
   always_ff @(posedge lnk_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         ls <= '0;
      end else begin
         ls <= next_ls; // see R13
      end
   end

   assign pcie_out         = st.pcie;
   assign smbus_out        = st.smbus;
   assign sel_out          = st.sel;
   assign lane_out         = st.lane;
   assign speed_cap_out    = st.speed;
   assign pkt_drop_out     = st.drop;
   assign lnk_sel_pcie_out = ls.sel_pcie;

   sel_rise_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $rose(st.rst_sync[1]) |=> sel_out == his_pkg::HIS_SEL_PCIE) // see R7
      else $error("rising reset did not select link");
   sel_fall_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      $fell(st.rst_sync[1]) |=> sel_out == his_pkg::HIS_SEL_SMBUS) // see R8
      else $error("falling reset did not select smbus");
   drop_pkt_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sw_edge && st.in_pkt |=> pkt_drop_out && !pcie_out.valid && !smbus_out.valid) // see R9
      else $error("in-flight packet not dropped");
   smb_speed_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_SMBUS |-> ##1 speed_cap_out == his_pkg::HIS_SPEED_10M) // see R15
      else $error("speed not limited on smbus");
   smb_lane_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_SMBUS |=> lane_out == his_pkg::HIS_LANE_OFF
      && !pcie_out.valid) // see R5
      else $error("link not off in sleep");
   lpi_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_PCIE && link_state_in.low_power_idle_state
      |=> lane_out == his_pkg::HIS_LANE_EIDLE) // see R4
      else $error("low power idle not electrical idle");
   pwr_idle_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_PCIE && link_state_in.phy_powered_down
      |=> lane_out == his_pkg::HIS_LANE_EIDLE) // see R2
      else $error("powered down not electrical idle");
   act_lane_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_PCIE && link_state_in == 4'b0001
      |=> lane_out == his_pkg::HIS_LANE_ACTIVE && !smbus_out.valid) // see R1
      else $error("active link not used");
   idle_lane_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_PCIE && link_state_in.link_idle
      |=> lane_out == his_pkg::HIS_LANE_EIDLE) // see R3
      else $error("idle link not electrical idle");
   replay_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sw_edge && st.ack_ptr != st.wr_ptr && !msg_ack_in |=> st.rd_ptr == $past(st.ack_ptr)) // see R10 see R11
      else $error("unacknowledged messages not rewound");
   once_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sw_edge |=> !sw_edge) // see R16
      else $error("switch triggered twice");
   boot_smb_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      !st.rst_sync[1] && !st.rst_seen |-> sel_out == his_pkg::HIS_SEL_SMBUS) // see R6
      else $error("smbus not kept while reset low");

   // beats only ever leave on the bus that is currently selected
   pcie_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      pcie_out.valid |-> sel_out == his_pkg::HIS_SEL_PCIE) // see R1
      else $error("link beat while smbus selected");
   smb_sel_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      smbus_out.valid |-> sel_out == his_pkg::HIS_SEL_SMBUS) // see R5
      else $error("smbus beat while link selected");
   pcie_speed_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sel_out == his_pkg::HIS_SEL_PCIE |=> speed_cap_out == his_pkg::HIS_SPEED_ANY) // see R15
      else $error("speed cap kept on link");
   edge_quiet_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      sw_edge |=> !pcie_out.valid && !smbus_out.valid) // see R9
      else $error("beat forwarded on switch cycle");
   drop_edge_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      pkt_drop_out |-> $past(sw_edge)) // see R9
      else $error("drop without switch");
   sync_stage_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      1'b1 |=> st.rst_sync[1] == $past(st.rst_sync[0])) // see R16
      else $error("reset sync stage skipped");
   ack_bound_a: assert property (@(posedge sys_clk_in) disable iff (!rstn_in)
      (st.wr_ptr - st.ack_ptr) <= (PW+1)'(MSG_DEPTH)) // see R10 see R11
      else $error("unacked count beyond depth");
   lnk_follow_a: assert property (@(posedge lnk_clk_in) disable iff (!rstn_in)
      ls.sel_sync[1] |=> lnk_sel_pcie_out) // see R16
      else $error("link side selection lost");

endmodule

// File: dv/his_host_model.sv
// far-side model: host mac driving the platform reset pin and acking messages
`timescale 1ns/1ps
module his_host_model (
   input  wire logic               sys_clk_in,
   input  wire logic               rstn_in,
   input  wire logic               s0_req_in,
   input  wire logic               ack_en_in,
   input  wire his_pkg::his_beat_t pcie_in,
   input  wire his_pkg::his_beat_t smbus_in,
   output logic                    platform_reset_n_out,
   output logic                    msg_ack_out
);
   // pin held low in reset: power and clock are not yet good
   always_ff @(posedge sys_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         platform_reset_n_out <= 1'b0;
         msg_ack_out          <= 1'b0;
      end else begin
         platform_reset_n_out <= s0_req_in;
         // acks given only on request (ack_en_in) so that resends can be seen
         msg_ack_out          <= ack_en_in & (pcie_in.valid | smbus_in.valid);
      end
   end
endmodule

// File: dv/testbench.sv
// self-checking testbench for the host interface switch
`timescale 1ns/1ps
module testbench;
   logic               sys_clk_in = 1'b0;
   logic               lnk_clk    = 1'b0;
   logic               rstn_in    = 1'b0;
   logic               s0_req     = 1'b0;
   logic               ack_en     = 1'b0;
   logic               plat_n;
   logic               ack;
   his_pkg::his_link_t link_state = '0;
   his_pkg::his_beat_t msg        = '0;
   his_pkg::his_beat_t pkt        = '0;
   his_pkg::his_beat_t pcie_out;
   his_pkg::his_beat_t smbus_out;
   his_pkg::his_sel_t  sel;
   his_pkg::his_lane_t lane;
   logic [1:0]         speed;
   logic               drop;
   logic               lnk_sel;
   int                 mismatches      = 0;
   int                 samples_checked = 0;
   // {s0, link state, sel, lane, speed}
   logic [10:0]        rows [5] = '{11'h453, 11'h048, 11'h617, 11'h4D7, 11'h517};

   always #25 sys_clk_in = ~sys_clk_in;
   // link clock offset so its edges never line up with the system clock
   initial begin
      #7;
      forever #80 lnk_clk = ~lnk_clk;
   end

   his_switch #(.MSG_DEPTH(4)) i_his_switch (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .platform_reset_n_in(plat_n),
      .lnk_clk_in(lnk_clk), .link_state_in(link_state), .msg_in(msg), .msg_ack_in(ack),
      .pkt_in(pkt), .pcie_out(pcie_out), .smbus_out(smbus_out), .sel_out(sel),
      .lane_out(lane), .speed_cap_out(speed), .pkt_drop_out(drop),
      .lnk_sel_pcie_out(lnk_sel));

   his_host_model i_his_host_model (
      .sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .s0_req_in(s0_req), .ack_en_in(ack_en),
      .pcie_in(pcie_out), .smbus_in(smbus_out), .platform_reset_n_out(plat_n),
      .msg_ack_out(ack));

   task automatic results;
      if (mismatches == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   task automatic cmp(string name, logic [9:0] exp, logic [9:0] got);
      samples_checked++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic cyc(int n);
      repeat (n) @(negedge sys_clk_in);
   endtask

   // 0: serial link beat, 1: smbus beat, 2: drop pulse
   task automatic wait_on(int which);
      for (int i = 0; i < 12; i++) begin
         @(negedge sys_clk_in);
         if ((which == 0 && pcie_out.valid === 1'b1) || (which == 1 && smbus_out.valid === 1'b1)
             || (which == 2 && drop === 1'b1)) return;
      end
      mismatches++;
      results();
   endtask

   initial begin
      cyc(8);
      rstn_in = 1'b1;
      foreach (rows[k]) begin
         s0_req = rows[k][10];
         link_state = rows[k][9:6];
         cyc(6);
         cmp("sel", 10'(rows[k][5:4]), 10'(sel));
         cmp("lane", 10'(rows[k][3:2]), 10'(lane));
         cmp("speed", 10'(rows[k][1:0]), 10'(speed));
      end
      // reset in mid-run, while the serial link is selected
      rstn_in = 1'b0;
      cyc(4);
      cmp("sel", 10'(his_pkg::HIS_SEL_SMBUS), 10'(sel));
      cmp("lane", 10'(his_pkg::HIS_LANE_OFF), 10'(lane));
      cmp("speed", 10'(his_pkg::HIS_SPEED_10M), 10'(speed));
      s0_req = 1'b0;
      link_state = 4'h1;
      rstn_in = 1'b1;
      cyc(2);
      s0_req = 1'b1;
      cyc(3);
      cmp("sel", 10'(his_pkg::HIS_SEL_SMBUS), 10'(sel));
      cyc(1);
      cmp("sel", 10'(his_pkg::HIS_SEL_PCIE), 10'(sel));
      for (int i = 0; i < 8 && lnk_sel !== 1'b1; i++) @(posedge lnk_clk);
      cmp("lnk_sel", 10'h1, 10'(lnk_sel));
      cyc(1);
      // unacked message must follow every switch-over
      msg = '{1'b1, 1'b1, 8'hA5};
      cyc(1);
      msg = '0;
      wait_on(0);
      cmp("pcie_byte", 10'h0A5, 10'(pcie_out.data));
      s0_req = 1'b0;
      wait_on(1);
      cmp("smbus_byte", 10'h0A5, 10'(smbus_out.data));
      // ack only after the resend on the link, else nothing is left to replay
      s0_req = 1'b1;
      wait_on(0);
      cmp("pcie_byte", 10'h0A5, 10'(pcie_out.data));
      ack_en = 1'b1;
      cyc(3);
      ack_en = 1'b0;
      // packet left open by the switch-over
      // beat appears one edge later and stands one cycle only
      pkt = '{1'b1, 1'b0, 8'h3C};
      wait_on(0);
      pkt = '0;
      cmp("pcie_byte", 10'h03C, 10'(pcie_out.data));
      s0_req = 1'b0;
      wait_on(2);
      cmp("drop", 10'h1, 10'(drop));
      cyc(3);
      cmp("speed", 10'(his_pkg::HIS_SPEED_10M), 10'(speed));
      results();
   end
endmodule
